// *** bmebl_pkg.sv ***
// Package for the boot mode selector and EPROM bootstrap loader.
// Assumes a single 125 MHz core clock and no register bus.
package bmebl_pkg;

  // Boot modes, one-hot
  typedef enum logic [2:0] {
    BMEBL_MODE_NONE  = 3'b001,
    BMEBL_MODE_HOST  = 3'b010,
    BMEBL_MODE_EPROM = 3'b100
  } bmebl_mode_t;

  // Loader states, one-hot
  typedef enum logic [4:0] {
    BMEBL_ST_RESET = 5'b00001,
    BMEBL_ST_ISSUE = 5'b00010,
    BMEBL_ST_WAIT  = 5'b00100,
    BMEBL_ST_WRITE = 5'b01000,
    BMEBL_ST_DONE  = 5'b10000
  } bmebl_state_t;

  // Internal memory write carrier
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [47:0] data;
  } bmebl_mem_wr_t;

  // Reset values of the boot channel
  localparam logic [15:0] CH8_CTRL_EPROM = 16'h02A1;
  localparam logic [15:0] CH8_CTRL_HOST = 16'h00A1;
  localparam logic [15:0] CH8_WORD_COUNT_RST = 16'h0100;
  localparam logic [15:0] CH8_EXT_COUNT_RST = 16'h0600;
  localparam logic [31:0] CH8_INT_INDEX_RST = 32'h0000_8000;
  localparam logic [23:0] EXT_ADDR_RST = 24'h00_0000;

  // Program counter values
  localparam logic [31:0] PC_NO_BOOT = 32'h0002_0004;
  localparam logic [31:0] PC_BOOT_IDLE = 32'h0000_8004;
  localparam logic [31:0] PC_BOOT_DONE = 32'h0000_8040;
  localparam logic [31:0] PC_RESUME = 32'h0000_8005;

  // Wait mode field codes and reset values
  localparam logic [1:0] WAIT_MODE_INT_ACK = 2'h0;
  localparam logic [1:0] WAIT_MODE_INT_ONLY = 2'h1;
  localparam logic [2:0] BOOT_WAIT_STATES_RST = 3'h6;
  localparam logic [1:0] BOOT_WAIT_MODE_RST = WAIT_MODE_INT_ACK;

  // Packing: six bytes per 48-bit word
  localparam logic [2:0] BYTES_PER_WORD = 3'h6;
  localparam int HOST_WIDTH_BITS = 8;
  localparam logic [1:0] HOST_WIDTH_8 = 2'h0;

endpackage : bmebl_pkg

// *** bmebl_wait_gen.sv ***
// Wait-state generator for boot memory accesses.
// Assumes start is a one-cycle pulse and ack_i is already synchronised.
`timescale 1ns/1ns
module bmebl_wait_gen (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic start_i,
  input wire logic [2:0] wait_states_i,
  input wire logic [1:0] wait_mode_i,
  input wire logic ack_i,
  // Result
  output logic done_o
);

  logic [2:0] cnt;
  logic busy;

  // Extension by external acknowledge only in mode 00
  wire use_ack = (wait_mode_i == bmebl_pkg::WAIT_MODE_INT_ACK);
  wire cnt_zero = (cnt == 3'h0);
  wire finish = busy && cnt_zero && (!use_ack || ack_i);

  // Count down the internal waits, then hold for ack
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 3'h0;
      busy <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= finish;
      if (start_i) begin
        cnt <= wait_states_i;
        busy <= 1'b1;
      end else if (finish) begin
        busy <= 1'b0;
      end else if (busy && !cnt_zero) begin
        cnt <= cnt - 3'h1;
      end
    end
  end

  // In mode 00 a low ack stretches the access without bound
  wait_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    busy && cnt_zero && use_ack && !ack_i |=> !done_o)
    else $error("access completed while ack low");

endmodule // bmebl_wait_gen

// *** bmebl_loader.sv ***
// Boot mode selection and byte-wide EPROM bootstrap loader.
// Assumes strap pins are asynchronous and the memory is a simple bus.
// Operation
// - Strap low, select pin low: no boot, fetch from 0x20004.
// - Strap low, select pin high: host boot, 8-bit host width.
// - Strap high: drive select pin as output, EPROM boot.
// - EPROM boot treats memory as 8 bits, low data lines.
// - Only bus owner drives select output; wire-OR is safe.
// - Instruction at 0x8004 is not executed during boot.
// - Channel control resets to 0x02A1 in EPROM boot mode.
// - Boot accesses use six wait states, seven cycles; here the read strobe stays low nine cycles.
// - Mode 00 low ack keeps inserting waits; mode 01 avoids it.
// - Word count 0x0100, external count 0x0600, index 0x8000.
// - On reset release: idle, PC 0x8004, load parameters, select.
// - Eight-bit master reads on data lines 7:0.
// - External address starts at zero, increments each byte.
// - Pack bytes into 48-bit words until 256 loaded.
// - Only boot select asserted; other selects inactive.
// - At count zero: stop, interrupt, release select, vector 0x8040.
// - Return from interrupt at vector resumes at 0x8005.
// - Override bit routes external DMA to boot select.
// - Override forces 8-to-48 packing for channel 8 reads.
// - With override, only DMA asserts boot select.
// - With override channel 9 reads/writes, no 8-bit packing.
`timescale 1ns/1ns
module bmebl_loader (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Strap pins and boot select pin (four signals)
  input wire logic eprom_boot_strap_i,
  input wire logic boot_memory_select_i,
  output logic boot_memory_select_o,
  output logic boot_memory_select_oe_n_o,
  // Multiprocessor bus ownership
  input wire logic bus_owner_i,
  // External bus
  output logic [23:0] ext_addr_o,
  output logic ext_rd_n_o,
  output logic [3:0] mem_select_n_o,
  input wire logic [7:0] external_port_data_lines_i,
  input wire logic ext_ack_i,
  // Configuration from system register
  input wire logic boot_select_override_i,
  input wire logic [1:0] boot_wait_mode_i,
  input wire logic boot_wait_mode_wr_i,
  input wire logic dma_active_i,
  input wire logic dma_ch9_i,
  input wire logic dma_write_i,
  input wire logic dma_pack8_i,
  input wire logic core_ext_access_i,
  input wire logic [3:0] core_mem_select_n_i,
  input wire logic return_from_interrupt_i,
  // Internal memory write
  output bmebl_pkg::bmebl_mem_wr_t mem_wr_o,
  // Status
  output bmebl_pkg::bmebl_mode_t boot_mode_o,
  output logic [15:0] ch8_dma_control_o,
  output logic [1:0] host_bus_width_o,
  output logic [31:0] pc_o,
  output logic core_idle_o,
  output logic ch8_done_interrupt_o,
  output logic [15:0] ch8_word_count_o,
  output logic [15:0] ch8_external_count_o,
  output logic override_error_o
);

  // Strap synchronisers
  logic strap_m, strap_s, bms_m, bms_s;
  logic in_reset;
  bmebl_pkg::bmebl_mode_t mode;
  bmebl_pkg::bmebl_state_t state;
  logic [31:0] ch8_internal_index;
  logic [2:0] byte_idx;
  logic [47:0] pack;
  logic [2:0] boot_wait_state_count;
  logic [1:0] boot_wait_mode;
  logic acc_start;
  logic acc_done;
  logic ack_m, ack_s;

  // Strap syncs run through reset, so the decode is settled at release
  always_ff @(posedge core_clk_i) begin
    strap_m <= eprom_boot_strap_i;
    strap_s <= strap_m;
    bms_m <= boot_memory_select_i;
    bms_s <= bms_m;
  end

  // Acknowledge sync idles high, like the keeper on the pin
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_m <= 1'b1;
      ack_s <= 1'b1;
    end else begin
      ack_m <= ext_ack_i;
      ack_s <= ack_m;
    end
  end

  // Decode of the synchronised straps
  wire bmebl_pkg::bmebl_mode_t strap_mode =
    strap_s ? bmebl_pkg::BMEBL_MODE_EPROM :
    bms_s ? bmebl_pkg::BMEBL_MODE_HOST :
    bmebl_pkg::BMEBL_MODE_NONE;
  wire eprom_mode = (mode == bmebl_pkg::BMEBL_MODE_EPROM);
  wire booting = eprom_mode && (state != bmebl_pkg::BMEBL_ST_DONE);
  wire last_byte = (byte_idx == bmebl_pkg::BYTES_PER_WORD - 3'h1);
  wire ext_zero = (ch8_external_count_o == 16'h0000);
  // Override path: only DMA, never channel 8 writes
  wire ovr_dma = boot_select_override_i && dma_active_i;
  wire ovr_bad = ovr_dma && ((!dma_ch9_i && dma_write_i) ||
                 (dma_ch9_i && dma_pack8_i));
  wire select_on = booting || (ovr_dma && !ovr_bad);
  wire [47:0] next_pack = {external_port_data_lines_i, pack[47:8]};

  // Sample the strap mode on the first edge after reset release; freeze afterwards
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_reset <= 1'b1;
      mode <= bmebl_pkg::BMEBL_MODE_NONE;
    end else begin
      in_reset <= 1'b0;
      if (in_reset) begin
        mode <= strap_mode;
      end
    end
  end

  // Boot wait fields; software may switch to internal-only wait
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_wait_state_count <= bmebl_pkg::BOOT_WAIT_STATES_RST;
      boot_wait_mode <= bmebl_pkg::BOOT_WAIT_MODE_RST;
    end else if (boot_wait_mode_wr_i) begin
      boot_wait_mode <= boot_wait_mode_i;
    end
  end

  bmebl_wait_gen u_wait (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(acc_start),
    .wait_states_i(boot_wait_state_count),
    .wait_mode_i(boot_wait_mode),
    .ack_i(ack_s),
    .done_o(acc_done)
  );

  // Boot sequencer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= bmebl_pkg::BMEBL_ST_RESET;
      ext_addr_o <= bmebl_pkg::EXT_ADDR_RST;
      ext_rd_n_o <= 1'b1;
      acc_start <= 1'b0;
      byte_idx <= 3'h0;
      pack <= 48'h0000_0000_0000;
      mem_wr_o <= '0;
      ch8_word_count_o <= bmebl_pkg::CH8_WORD_COUNT_RST;
      ch8_external_count_o <= bmebl_pkg::CH8_EXT_COUNT_RST;
      ch8_internal_index <= bmebl_pkg::CH8_INT_INDEX_RST;
      ch8_done_interrupt_o <= 1'b0;
      pc_o <= bmebl_pkg::PC_BOOT_IDLE;
      core_idle_o <= 1'b1;
    end else begin
      acc_start <= 1'b0;
      mem_wr_o.we <= 1'b0;
      ch8_done_interrupt_o <= 1'b0;
      unique case (state)
        bmebl_pkg::BMEBL_ST_RESET: begin
          if (!in_reset) begin
            if (eprom_mode) begin
              pc_o <= bmebl_pkg::PC_BOOT_IDLE;
              state <= bmebl_pkg::BMEBL_ST_ISSUE;
            end else if (mode == bmebl_pkg::BMEBL_MODE_NONE) begin
              pc_o <= bmebl_pkg::PC_NO_BOOT;
              core_idle_o <= 1'b0;
              state <= bmebl_pkg::BMEBL_ST_DONE;
            end else begin
              state <= bmebl_pkg::BMEBL_ST_DONE; // Host loads
            end
          end
        end
        bmebl_pkg::BMEBL_ST_ISSUE: begin
          ext_rd_n_o <= 1'b0;
          acc_start <= 1'b1;
          state <= bmebl_pkg::BMEBL_ST_WAIT;
        end
        bmebl_pkg::BMEBL_ST_WAIT: begin
          if (acc_done) begin
            ext_rd_n_o <= 1'b1;
            pack <= next_pack;
            ext_addr_o <= ext_addr_o + 24'h00_0001;
            ch8_external_count_o <= ch8_external_count_o - 16'h0001;
            byte_idx <= last_byte ? 3'h0 : byte_idx + 3'h1;
            state <= last_byte ? bmebl_pkg::BMEBL_ST_WRITE :
                     bmebl_pkg::BMEBL_ST_ISSUE;
          end
        end
        bmebl_pkg::BMEBL_ST_WRITE: begin
          mem_wr_o.we <= 1'b1;
          mem_wr_o.addr <= ch8_internal_index;
          mem_wr_o.data <= pack;
          ch8_internal_index <= ch8_internal_index + 32'h0000_0001;
          ch8_word_count_o <= ch8_word_count_o - 16'h0001;
          if (ext_zero) begin
            ch8_done_interrupt_o <= 1'b1;
            pc_o <= bmebl_pkg::PC_BOOT_DONE;
            core_idle_o <= 1'b0;
            state <= bmebl_pkg::BMEBL_ST_DONE;
          end else begin
            state <= bmebl_pkg::BMEBL_ST_ISSUE;
          end
        end
        bmebl_pkg::BMEBL_ST_DONE: begin
          if (return_from_interrupt_i && eprom_mode &&
              pc_o == bmebl_pkg::PC_BOOT_DONE) begin
            pc_o <= bmebl_pkg::PC_RESUME;
          end
        end
      endcase
    end
  end

  // Pins and configuration outputs, all registered
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_memory_select_o <= 1'b1;
      boot_memory_select_oe_n_o <= 1'b1;
      mem_select_n_o <= 4'hF;
      boot_mode_o <= bmebl_pkg::BMEBL_MODE_NONE;
      ch8_dma_control_o <= bmebl_pkg::CH8_CTRL_HOST;
      host_bus_width_o <= bmebl_pkg::HOST_WIDTH_8;
      override_error_o <= 1'b0;
    end else begin
      boot_mode_o <= mode;
      override_error_o <= ovr_bad;
      // Pin is an output only in EPROM mode and only for bus owner
      boot_memory_select_oe_n_o <= !(eprom_mode && bus_owner_i);
      boot_memory_select_o <= !(select_on && !in_reset);
      mem_select_n_o <= select_on ? 4'hF : core_mem_select_n_i;
      if (in_reset) begin
        ch8_dma_control_o <= (strap_mode == bmebl_pkg::BMEBL_MODE_EPROM) ?
          bmebl_pkg::CH8_CTRL_EPROM : bmebl_pkg::CH8_CTRL_HOST;
        host_bus_width_o <= bmebl_pkg::HOST_WIDTH_8;
      end else if (boot_select_override_i && !booting) begin
        ch8_dma_control_o <= bmebl_pkg::CH8_CTRL_EPROM;
      end
    end
  end

  // Core accesses never reach boot space under override
  core_not_boot_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    core_ext_access_i && !dma_active_i && !booting |=> boot_memory_select_o)
    else $error("core access asserted boot select");

  // Address steps by one on each byte
  addr_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == bmebl_pkg::BMEBL_ST_WAIT && acc_done |=>
    ext_addr_o == $past(ext_addr_o) + 24'h00_0001)
    else $error("address did not advance");

  // Done pulse comes with the vector
  done_vector_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ch8_done_interrupt_o |-> pc_o == bmebl_pkg::PC_BOOT_DONE &&
    ch8_external_count_o == 16'h0000)
    else $error("done without vector");

  // Other selects idle while booting
  selects_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    booting && !in_reset |=> mem_select_n_o == 4'hF)
    else $error("memory select active in boot");

  // Packed word written every six bytes
  word_pack_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mem_wr_o.we |-> $past(ch8_external_count_o, 2) -
    ch8_external_count_o == 16'h0001 && byte_idx == 3'h0)
    else $error("word written off byte boundary");

  // Channel control in EPROM mode
  ctrl_value_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    eprom_mode && !in_reset |-> ch8_dma_control_o == bmebl_pkg::CH8_CTRL_EPROM)
    else $error("channel control wrong");

  // Pin enable only for bus owner in EPROM mode
  pin_owner_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !boot_memory_select_oe_n_o |-> $past(eprom_mode) && $past(bus_owner_i))
    else $error("select pin driven while not owner");

  // No boot starts at external address
  no_boot_pc_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mode == bmebl_pkg::BMEBL_MODE_NONE && state == bmebl_pkg::BMEBL_ST_DONE
    |-> pc_o == bmebl_pkg::PC_NO_BOOT && !core_idle_o)
    else $error("no boot start address wrong");

endmodule // bmebl_loader

// *** bmebl_eprom_model.sv ***
// Byte-wide boot memory model that answers the loader's reads.
// Assumes active-low select and read strobe; acknowledge is pulled up.
`timescale 1ns/1ns
module bmebl_eprom_model (
  // Clock
  input wire logic core_clk_i,
  // Bus from the loader
  input wire logic sel_n_i,
  input wire logic rd_n_i,
  input wire logic [23:0] addr_i,
  // Another device holding acknowledge low
  input wire logic stall_i,
  // Answer
  output logic [7:0] data_o,
  output logic ack_o
);
  logic [7:0] last = 8'h3C;
  wire drive = !sel_n_i && !rd_n_i;
  // Byte content is a fixed function of the byte address
  function automatic logic [7:0] rom(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  // Released lines show the inverse, so a stale byte never matches
  always @(posedge core_clk_i) begin
    if (drive) last <= rom(addr_i);
  end
  assign data_o = drive ? rom(addr_i) : ~last;
  // Keeper holds acknowledge high unless someone pulls it down
  assign ack_o = !stall_i;
endmodule // bmebl_eprom_model

// *** test_boot_mode_eprom_bootstrap.sv ***
// Self-checking bench for the boot mode selector and bootstrap loader.
// Assumes the package and the memory model are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_boot_mode_eprom_bootstrap;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic strap = 1'b0, strap_pin = 1'b0, owner = 1'b1, stall = 1'b0;
  logic boot_select_override = 1'b0, wm_wr = 1'b0, dma_act = 1'b0, ch9 = 1'b0;
  logic dwr = 1'b0, pk8 = 1'b0, core_acc = 1'b0, return_from_interrupt = 1'b0;
  logic boot_on = 1'b0, rd_q = 1'b1;
  logic [1:0] wm = 2'h0;
  logic [3:0] core_sel_n = 4'hF;
  logic sel_o, sel_oe_n, rd_n, ack, idle, done_irq, ovr_err;
  logic [23:0] addr;
  logic [3:0] msel_n;
  logic [7:0] data;
  logic [15:0] ctrl, wcnt, ecnt, ecnt_hold;
  logic [1:0] hbw;
  logic [31:0] pc;
  bmebl_pkg::bmebl_mem_wr_t mwr;
  bmebl_pkg::bmebl_mode_t mode;
  int num_errors = 0, n_tests = 0;
  int nbyte = 0, nword = 0, lowrun = 0, minrun = 99;
  // Override cases: {ch9, write, pack8} and expected select level
  logic [2:0] ovr_cfg [4] = '{3'h0, 3'h6, 3'h2, 3'h5};
  logic ovr_sel [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  // Select pin: strap level unless the loader drives it
  wire sel_pin = sel_oe_n ? strap_pin : sel_o;

  bmebl_loader DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .eprom_boot_strap_i(strap), .boot_memory_select_i(sel_pin),
    .boot_memory_select_o(sel_o), .boot_memory_select_oe_n_o(sel_oe_n),
    .bus_owner_i(owner), .ext_addr_o(addr), .ext_rd_n_o(rd_n),
    .mem_select_n_o(msel_n), .external_port_data_lines_i(data),
    .ext_ack_i(ack), .boot_select_override_i(boot_select_override),
    .boot_wait_mode_i(wm), .boot_wait_mode_wr_i(wm_wr),
    .dma_active_i(dma_act), .dma_ch9_i(ch9), .dma_write_i(dwr),
    .dma_pack8_i(pk8), .core_ext_access_i(core_acc),
    .core_mem_select_n_i(core_sel_n), .return_from_interrupt_i(return_from_interrupt),
    .mem_wr_o(mwr), .boot_mode_o(mode), .ch8_dma_control_o(ctrl),
    .host_bus_width_o(hbw), .pc_o(pc), .core_idle_o(idle),
    .ch8_done_interrupt_o(done_irq), .ch8_word_count_o(wcnt),
    .ch8_external_count_o(ecnt), .override_error_o(ovr_err));

  bmebl_eprom_model mem (.core_clk_i(core_clk_i), .sel_n_i(sel_pin),
    .rd_n_i(rd_n), .addr_i(addr), .stall_i(stall), .data_o(data),
    .ack_o(ack));

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Expected contents, worked out independently of the model
  function automatic logic [47:0] word(input int k);
    logic [47:0] w;
    int a;
    for (int i = 0; i < 6; i++) begin
      a = 6 * k + i;
      w[8*i +: 8] = a[7:0] ^ a[15:8] ^ 8'hA5;
    end
    return w;
  endfunction

  // Watch byte reads and packed words, sampled where outputs are settled
  always @(negedge core_clk_i) begin
    rd_q <= rd_n;
    lowrun <= rd_n ? 0 : lowrun + 1;
    if (rd_n && !rd_q && boot_on && lowrun < minrun) minrun <= lowrun;
    if (!rd_n && rd_q && boot_on) begin
      `CHK(addr, nbyte[23:0])
      `CHK(msel_n, 4'hF)
      `CHK(sel_o, 1'b0)
      nbyte <= nbyte + 1;
    end
    if (mwr.we && boot_on) begin
      `CHK(mwr.addr, 32'h0000_8000 + nword)
      `CHK(mwr.data, word(nword))
      nword <= nword + 1;
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Reset for four cycles with straps settled beforehand
  task automatic restart(input logic s, input logic p);
    @(negedge core_clk_i);
    rst_n_i = 1'b0;
    strap = s;
    strap_pin = p;
    tick(4);
    rst_n_i = 1'b1;
    tick(2);
  endtask

  // Bounded wait for the boot-done pulse
  task automatic wait_irq(input int bound);
    int i;
    for (i = 0; i < bound && done_irq !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (i == bound) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  initial begin
    restart(1'b0, 1'b0);
    `CHK(mode, bmebl_pkg::BMEBL_MODE_NONE)
    `CHK(pc, bmebl_pkg::PC_NO_BOOT)
    `CHK(sel_oe_n, 1'b1)
    restart(1'b0, 1'b1);
    `CHK(mode, bmebl_pkg::BMEBL_MODE_HOST)
    `CHK(hbw, bmebl_pkg::HOST_WIDTH_8)
    `CHK(ctrl, bmebl_pkg::CH8_CTRL_HOST)
    tick(20);
    `CHK(rd_n, 1'b1)
    // Not the bus owner: select pin must stay released
    owner = 1'b0;
    restart(1'b1, 1'b0);
    `CHK(mode, bmebl_pkg::BMEBL_MODE_EPROM)
    `CHK(sel_oe_n, 1'b1)
    owner = 1'b1;
    core_sel_n = 4'hE;
    restart(1'b1, 1'b1);
    strap = 1'b0; // Late strap change must be ignored
    boot_on = 1'b1;
    `CHK(sel_oe_n, 1'b0)
    `CHK(ctrl, bmebl_pkg::CH8_CTRL_EPROM)
    `CHK(wcnt, bmebl_pkg::CH8_WORD_COUNT_RST)
    `CHK(ecnt, bmebl_pkg::CH8_EXT_COUNT_RST)
    `CHK(pc, bmebl_pkg::PC_BOOT_IDLE)
    // Acknowledge held low in reset wait mode stalls the boot
    stall = 1'b1;
    tick(60);
    ecnt_hold = ecnt;
    tick(40);
    `CHK(ecnt, ecnt_hold)
    stall = 1'b0;
    tick(100);
    // Internal-only waits let the boot run past a low acknowledge
    wm = bmebl_pkg::WAIT_MODE_INT_ONLY;
    wm_wr = 1'b1;
    tick(1);
    wm_wr = 1'b0;
    stall = 1'b1;
    ecnt_hold = ecnt;
    tick(2000);
    `CHK(ecnt < ecnt_hold, 1'b1)
    `CHK(idle, 1'b1)
    `CHK(pc, bmebl_pkg::PC_BOOT_IDLE)
    `CHK(mode, bmebl_pkg::BMEBL_MODE_EPROM)
    wait_irq(30000);
    `CHK(done_irq, 1'b1)
    tick(2);
    boot_on = 1'b0;
    `CHK(done_irq, 1'b0)
    `CHK(nword, 256)
    `CHK(nbyte, 1536)
    `CHK(ecnt, 16'h0000)
    `CHK(wcnt, 16'h0000)
    `CHK(minrun >= 7, 1'b1)
    `CHK(pc, bmebl_pkg::PC_BOOT_DONE)
    `CHK(sel_o, 1'b1)
    `CHK(msel_n, 4'hE)
    return_from_interrupt = 1'b1;
    tick(1);
    return_from_interrupt = 1'b0;
    tick(1);
    `CHK(pc, bmebl_pkg::PC_RESUME)
    // Override: legal transfers take the boot select, others refused
    boot_select_override = 1'b1;
    dma_act = 1'b1;
    for (int k = 0; k < 4; k++) begin
      {ch9, dwr, pk8} = ovr_cfg[k];
      tick(3);
      `CHK(sel_o, ovr_sel[k])
      `CHK(ovr_err, ovr_sel[k])
    end
    dma_act = 1'b0;
    core_acc = 1'b1;
    core_sel_n = 4'hD;
    tick(3);
    `CHK(sel_o, 1'b1)
    `CHK(msel_n, 4'hD)
    report_and_stop();
  end
endmodule // test_boot_mode_eprom_bootstrap
